// ### include/tc1_timer_map.vh
// Constants for the sixteen-bit timer/counter: register offsets, field
// positions, reset values and codes. Definitions only.
//
// Overview of operation
// - Wide mode: low-byte read copies live high byte into the high buffer.
// - Wide mode: high write loads buffer; low write loads all sixteen bits.
// - Narrow mode: high and low bytes are read and written directly.
// - Low-byte writes clear the prescaler; high-byte writes do not.
// - Prescale field bits 5:4 divides by 1, 2, 4 or 8.
// - Source clear: count per instruction cycle; set: external rising edges.
// - Sync bit picks synchronized or asynchronous counting; ignored for internal. Here the pin is always synchronized; the bit only blocks trigger clears.
// - Run bit starts counting; clearing it holds the count.
// - Oscillator enable disables oscillator pin inputs; they read zero.
// - Bit 6 reads one when system clock comes from the oscillator.
// - External source is pin, or oscillator when enabled; with it enabled outside allowed modes nothing counts.
// - A falling edge must be seen before the first counted rising edge.
// - Count wraps FFFFh to 0000h and each wrap sets the overflow flag.
// - Interrupt request only while overflow interrupt enable is set.
// - Compare mode 1011 special event trigger clears the count.
// - Trigger clear applies in timer and synchronous counter modes.
// - A software count write wins over a coinciding trigger clear.
// - Trigger from the second compare unit never sets the overflow flag.
// - Oscillator clocks the counter only while lp_or_intosc_mode is set.
`ifndef TC1_TIMER_MAP_VH
`define TC1_TIMER_MAP_VH

`define TC1_OFF_CONTROL     8'h00
`define TC1_OFF_COUNT_LOW   8'h04
`define TC1_OFF_COUNT_HIGH  8'h08
`define TC1_OFF_FLAGS       8'h0c
`define TC1_OFF_ENABLES     8'h10

`define TC1_BIT_RUN         0
`define TC1_BIT_SOURCE      1
`define TC1_BIT_SYNC_BYPASS 2
`define TC1_BIT_LP_OSC_EN   3
`define TC1_BIT_PS_LO       4
`define TC1_BIT_PS_HI       5
`define TC1_BIT_SYSCLK_LP   6
`define TC1_BIT_WIDE        7

`define TC1_CONTROL_RESET   8'h00
`define TC1_COUNT_RESET     16'h0000
`define TC1_COUNT_MAX       16'hffff
`define TC1_CMP_SPECIAL     4'hb
`define TC1_INST_DIV_LAST   2'h3

`define TC1_RESP_OKAY       2'h0
`define TC1_RESP_SLVERR     2'h2

`endif

// ### rtl/tc1_pin_sync.v
// Three-stage synchronizer for a level arriving from outside the clock domain.
// Assumes one clock; the output changes only when stages two and three agree.
`timescale 1ns/1ps

module tc1_pin_sync (
    // Clock and reset
    input  wire aclk,
    input  wire aresetn,
    // Level in and out
    input  wire pin_in,
    output reg  level_r
);

reg s1_r;
reg s2_r;
reg s3_r;

always @(posedge aclk) begin
    if (!aresetn) begin
        s1_r    <= 1'b0;
        s2_r    <= 1'b0;
        s3_r    <= 1'b0;
        level_r <= 1'b0;
    end else begin
        s1_r <= pin_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        // Agreement of two settled stages filters a single metastable sample.
        if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end
end

endmodule

// ### rtl/tc1_timer_counter.v
// Sixteen-bit timer/counter with prescaler, overflow flag and AXI4-Lite access.
// Assumes one system clock aclk; the count pin and the oscillator clock are
// asynchronous levels; compare triggers and mode inputs share aclk.
`include "tc1_timer_map.vh"
`timescale 1ns/1ps

module tc1_timer_counter (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // External count sources
    input  wire        external_count_input,
    input  wire        timer_lp_oscillator,
    // Oscillator pins and their port view
    input  wire [1:0]  osc_pin_levels,
    output reg  [1:0]  osc_pin_port_bits,
    output reg         osc_pin_input_enable,
    // System oscillator status
    input  wire        lp_or_intosc_mode,
    input  wire        sysclk_from_lp_osc,
    // Compare unit special event triggers
    input  wire [3:0]  compare_unit_a_mode,
    input  wire [3:0]  compare_unit_b_mode,
    input  wire        compare_a_trigger,
    input  wire        compare_b_trigger,
    // Interrupt request
    output reg         overflow_irq
);

////////////////////////////////////////////////////////////////////////////////

reg  [7:0]  control_r;
reg  [15:0] count_r;
reg  [7:0]  high_buf_r;
reg  [2:0]  pres_cnt_r;
reg  [1:0]  inst_cnt_r;
reg         overflow_flag_r;
reg         overflow_irq_enable_r;
reg         ext_prev_r;
reg         armed_r;

reg         aw_got_r;
reg         w_got_r;
reg  [7:0]  awaddr_q_r;
reg  [7:0]  wdata_q_r;
reg         wstrb0_q_r;

wire        pin_level;
wire        osc_level;
wire [1:0]  osc_pins_sync;

wire        wide_access_mode    = control_r[`TC1_BIT_WIDE];
wire [1:0]  input_prescale_select = control_r[`TC1_BIT_PS_HI:`TC1_BIT_PS_LO];
wire        lp_osc_enable       = control_r[`TC1_BIT_LP_OSC_EN];
wire        ext_sync_bypass     = control_r[`TC1_BIT_SYNC_BYPASS];
wire        count_source_select = control_r[`TC1_BIT_SOURCE];
wire        counter_run         = control_r[`TC1_BIT_RUN];

////////////////////////////////////////////////////////////////////////////////
// Synchronizers for asynchronous levels.

tc1_pin_sync u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (external_count_input),
    .level_r (pin_level)
);

tc1_pin_sync u_osc_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (timer_lp_oscillator),
    .level_r (osc_level)
);

tc1_pin_sync u_osc_pin0_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (osc_pin_levels[0]),
    .level_r (osc_pins_sync[0])
);

tc1_pin_sync u_osc_pin1_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (osc_pin_levels[1]),
    .level_r (osc_pins_sync[1])
);

////////////////////////////////////////////////////////////////////////////////
// Bus write and read strobes.

wire wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
wire wr_lane = wr_fire & wstrb0_q_r;
wire rd_fire = s_axi_arvalid & s_axi_arready;

wire wr_ctl  = wr_lane & (awaddr_q_r == `TC1_OFF_CONTROL);
wire wr_low  = wr_lane & (awaddr_q_r == `TC1_OFF_COUNT_LOW);
wire wr_high = wr_lane & (awaddr_q_r == `TC1_OFF_COUNT_HIGH);
wire wr_flg  = wr_lane & (awaddr_q_r == `TC1_OFF_FLAGS);
wire wr_ien  = wr_lane & (awaddr_q_r == `TC1_OFF_ENABLES);
wire rd_low  = rd_fire & (s_axi_araddr == `TC1_OFF_COUNT_LOW);

wire wr_map_ok = (awaddr_q_r == `TC1_OFF_CONTROL) |
                 (awaddr_q_r == `TC1_OFF_COUNT_LOW) |
                 (awaddr_q_r == `TC1_OFF_COUNT_HIGH) |
                 (awaddr_q_r == `TC1_OFF_FLAGS) |
                 (awaddr_q_r == `TC1_OFF_ENABLES);

// In wide mode a high-byte write only lands in the buffer.
wire wr_high_direct = wr_high & ~wide_access_mode;
wire wr_count       = wr_low | wr_high;

////////////////////////////////////////////////////////////////////////////////
// Count source selection and edge qualification.

// The oscillator drives counting only in the oscillator modes that share it.
wire osc_usable  = lp_osc_enable & lp_or_intosc_mode;
wire ext_level   = lp_osc_enable ? (osc_usable & osc_level) : pin_level;
wire ext_rise    = ext_level & ~ext_prev_r;
wire ext_fall    = ~ext_level & ext_prev_r;
wire inst_tick   = (inst_cnt_r == `TC1_INST_DIV_LAST);

// External rising edges count only after a registered falling edge.
wire src_tick    = count_source_select ? (ext_rise & armed_r) : inst_tick;

wire [2:0] pres_last = (input_prescale_select == 2'h0) ? 3'h0 :
                       (input_prescale_select == 2'h1) ? 3'h1 :
                       (input_prescale_select == 2'h2) ? 3'h3 : 3'h7;
wire pres_done   = (pres_cnt_r == pres_last);
wire count_tick  = counter_run & src_tick & pres_done;

// Asynchronous counting cannot honour a trigger clear, so it is ignored.
wire async_mode  = count_source_select & ext_sync_bypass;
wire trig_a      = compare_a_trigger & (compare_unit_a_mode == `TC1_CMP_SPECIAL);
wire trig_b      = compare_b_trigger & (compare_unit_b_mode == `TC1_CMP_SPECIAL);
wire trig_clear  = (trig_a | trig_b) & ~async_mode;

// A trigger clear takes the count to zero without wrapping.
wire wrap        = count_tick & ~trig_clear & (count_r == `TC1_COUNT_MAX);

////////////////////////////////////////////////////////////////////////////////
// Timer datapath.

always @(posedge aclk) begin
    if (!aresetn) begin
        inst_cnt_r <= 2'h0;
        pres_cnt_r <= 3'h0;
        count_r    <= `TC1_COUNT_RESET;
        high_buf_r <= 8'h00;
        ext_prev_r <= 1'b0;
        armed_r    <= 1'b0;
    end else begin
        inst_cnt_r <= inst_cnt_r + 2'h1;
        ext_prev_r <= ext_level;

        if (wr_low) begin
            pres_cnt_r <= 3'h0;
        end else if (counter_run & src_tick) begin
            pres_cnt_r <= pres_done ? 3'h0 : pres_cnt_r + 3'h1;
        end

        // Count writes and stopping both demand a fresh falling edge.
        if (wr_count | ~counter_run) begin
            armed_r <= 1'b0;
        end else if (ext_fall) begin
            armed_r <= 1'b1;
        end

        if (wr_low) begin
            // Wide mode writes all sixteen bits at once.
            count_r <= {(wide_access_mode ? high_buf_r : count_r[15:8]), wdata_q_r};
        end else if (wr_high_direct) begin
            count_r <= {wdata_q_r, count_r[7:0]};
        end else if (trig_clear) begin
            count_r <= `TC1_COUNT_RESET;
        end else if (count_tick) begin
            count_r <= count_r + 16'h0001;
        end

        if (wr_high & wide_access_mode) begin
            high_buf_r <= wdata_q_r;
        end else if (rd_low & wide_access_mode) begin
            high_buf_r <= count_r[15:8];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Control, flag and enable registers.

always @(posedge aclk) begin
    if (!aresetn) begin
        control_r             <= `TC1_CONTROL_RESET;
        overflow_flag_r       <= 1'b0;
        overflow_irq_enable_r <= 1'b0;
    end else begin
        if (wr_ctl) begin
            control_r <= wdata_q_r;
        end
        // Hardware set beats a software clear in the same cycle.
        if (wrap) begin
            overflow_flag_r <= 1'b1;
        end else if (wr_flg & wdata_q_r[0]) begin
            overflow_flag_r <= 1'b0;
        end
        if (wr_ien) begin
            overflow_irq_enable_r <= wdata_q_r[0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs toward the chip.

always @(posedge aclk) begin
    if (!aresetn) begin
        overflow_irq         <= 1'b0;
        osc_pin_port_bits    <= 2'h0;
        osc_pin_input_enable <= 1'b1;
    end else begin
        overflow_irq         <= overflow_flag_r & overflow_irq_enable_r;
        osc_pin_input_enable <= ~lp_osc_enable;
        osc_pin_port_bits    <= lp_osc_enable ? 2'h0 : osc_pins_sync;
    end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write channel. Address and data are taken in either order.

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `TC1_RESP_OKAY;
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        awaddr_q_r    <= 8'h00;
        wdata_q_r     <= 8'h00;
        wstrb0_q_r    <= 1'b0;
    end else begin
        if (s_axi_awvalid & s_axi_awready) begin
            awaddr_q_r    <= s_axi_awaddr;
            aw_got_r      <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            wdata_q_r    <= s_axi_wdata[7:0];
            wstrb0_q_r   <= s_axi_wstrb[0];
            w_got_r      <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (wr_fire) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map_ok ? `TC1_RESP_OKAY : `TC1_RESP_SLVERR;
        end
        if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read channel. One read at a time; data registered at acceptance.

reg [7:0] rd_byte;
reg       rd_ok;

always @* begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
        `TC1_OFF_CONTROL: begin
            // Bit 6 is live status, never the stored value.
            rd_byte = {control_r[7], sysclk_from_lp_osc, control_r[5:0]};
        end
        `TC1_OFF_COUNT_LOW: begin
            rd_byte = count_r[7:0];
        end
        `TC1_OFF_COUNT_HIGH: begin
            rd_byte = wide_access_mode ? high_buf_r : count_r[15:8];
        end
        `TC1_OFF_FLAGS: begin
            rd_byte = {7'h00, overflow_flag_r};
        end
        `TC1_OFF_ENABLES: begin
            rd_byte = {7'h00, overflow_irq_enable_r};
        end
        default: begin
            rd_ok = 1'b0;
        end
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `TC1_RESP_OKAY;
    end else begin
        if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= rd_ok ? `TC1_RESP_OKAY : `TC1_RESP_SLVERR;
        end
        if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule

// ### sim/tc1_count_src.sv
// Model of the external count clock: bursts of rising edges on request.
// Assumes the bench raises go for one cycle; the pin idles low between bursts.
`timescale 1ns/1ps

module tc1_count_src #(
    parameter int HALF = 320
) (
    // Clock
    input  logic       aclk,
    // Burst request
    input  logic [7:0] n,
    input  logic       go,
    // Count pin and burst status
    output logic       pin,
    output logic       busy
);
    // The extra 7 ns keeps the pin edges drifting against aclk.
    initial begin
        pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge aclk iff go);
            busy = 1'b1;
            repeat (n) begin
                #(HALF + 7) pin = 1'b1;
                #(HALF) pin = 1'b0;
            end
            #(HALF) busy = 1'b0;
        end
    end
endmodule

// ### sim/tc1_timer_counter_chk.sv
// Bus and pin checks for the timer/counter, bound to its top module.
// Assumes one clock aclk and a synchronous active-low reset.
`timescale 1ns/1ps

module tc1_timer_chk (
    // Clock and reset
    input logic        aclk,
    input logic        aresetn,
    // Bus handshakes
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // Oscillator pin view
    input logic [1:0]  osc_pin_port_bits,
    input logic        osc_pin_input_enable
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("write response missing");
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read data missing");
    a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("read upper bits set");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
    a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write response not retired");
    a_b_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2) else $error("bad bresp");
    a_pin_quiet: assert property (!osc_pin_input_enable [*2] |-> osc_pin_port_bits == 2'b00)
        else $error("oscillator pins not zero");
endmodule

bind tc1_timer_counter tc1_timer_chk i_tc1_timer_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .osc_pin_port_bits, .osc_pin_input_enable);

// ### sim/test_tc1_timer_counter.sv
// Self-checking bench for the sixteen-bit timer/counter over AXI4-Lite.
// Assumes the count source model drives the count pin and the checker is bound.
`include "tc1_timer_map.vh"
`timescale 1ns/1ps

module test_tc1_timer_counter;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        external_count_input, lp_or_intosc_mode, sysclk_from_lp_osc, compare_a_trigger, compare_b_trigger;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        osc_pin_input_enable, overflow_irq, go, busy;
    logic [1:0]  s_axi_bresp, s_axi_rresp, osc_pin_levels, osc_pin_port_bits, lastb, lastr;
    logic [3:0]  s_axi_wstrb, compare_unit_a_mode, compare_unit_b_mode;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, n, rv;
    logic [15:0] mc, v, w;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int          errors, tests_run, cyc, tb_b, t, i;

    tc1_timer_counter i_tc1_timer_counter (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .external_count_input, .timer_lp_oscillator(external_count_input), .osc_pin_levels, .osc_pin_port_bits,
        .osc_pin_input_enable, .lp_or_intosc_mode, .sysclk_from_lp_osc, .compare_unit_a_mode,
        .compare_unit_b_mode, .compare_a_trigger, .compare_b_trigger, .overflow_irq);
    tc1_count_src i_tc1_count_src (.aclk, .n, .go, .pin(external_count_input), .busy);

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;
    always @(posedge aclk) osc_pin_levels <= 2'($urandom);

    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g, input int tol);
        tests_run++;
        if ($isunknown(g) || g > e + tol || g + tol < e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Ready and response are read right after the edge, so they hold the values sampled at it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($urandom);
        // The write lands one edge before bvalid is first seen, whatever bready does.
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (!s_axi_bvalid) tb_b = cyc;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        lastb = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom);
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        rv = s_axi_rdata[7:0];
        lastr = s_axi_rresp;
    endtask
    task automatic rdc(output logic [15:0] c);
        rd(`TC1_OFF_COUNT_LOW);
        c[7:0] = rv;
        rd(`TC1_OFF_COUNT_HIGH);
        c[15:8] = rv;
    endtask
    task automatic pulses(input logic [7:0] k);
        n <= k;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        do @(posedge aclk); while (busy);
    endtask
    task automatic test_done;
        $display("Checks made %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hcf80));
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, go, n, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, lp_or_intosc_mode, sysclk_from_lp_osc, compare_a_trigger, compare_b_trigger} = '0;
        {compare_unit_a_mode, compare_unit_b_mode} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`TC1_OFF_CONTROL);
        chk("control reset", 16'h0, {8'h0, rv}, 0);
        chk("pin input on", 16'h1, {15'h0, osc_pin_input_enable}, 0);
        sysclk_from_lp_osc <= 1'b1;
        wr(`TC1_OFF_CONTROL, 8'h08);
        rd(`TC1_OFF_CONTROL);
        chk("control", 16'h48, {8'h0, rv}, 0);
        chk("pins", 16'h0, {14'h0, osc_pin_port_bits, 1'b0} | {15'h0, osc_pin_input_enable}, 0);
        wr(8'h14, 8'h5a);
        chk("unmapped bresp", 16'h2, {14'h0, lastb}, 0);
        rd(8'h14);
        chk("unmapped read", 16'h2, {6'h0, rv, lastr}, 0);
        $display("register map test done");
        wr(`TC1_OFF_CONTROL, 8'h00);
        mc = 16'($urandom);
        wr(`TC1_OFF_COUNT_HIGH, mc[15:8]);
        wr(`TC1_OFF_COUNT_LOW, mc[7:0]);
        rdc(v);
        chk("narrow count", mc, v, 0);
        wr(`TC1_OFF_CONTROL, 8'h80);
        wr(`TC1_OFF_COUNT_HIGH, 8'h5c);
        rdc(v);
        chk("wide high held", mc, v, 0);
        wr(`TC1_OFF_COUNT_HIGH, 8'h5c);
        wr(`TC1_OFF_COUNT_LOW, 8'ha3);
        rdc(v);
        chk("wide write", 16'h5ca3, v, 0);
        $display("access mode test done");
        wr(`TC1_OFF_CONTROL, 8'h00);
        wr(`TC1_OFF_COUNT_HIGH, 8'hff);
        wr(`TC1_OFF_COUNT_LOW, 8'hf0);
        wr(`TC1_OFF_CONTROL, 8'h01);
        repeat (100) @(posedge aclk);
        rd(`TC1_OFF_FLAGS);
        chk("overflow flag", 16'h1, {8'h0, rv}, 0);
        chk("irq masked", 16'h0, {15'h0, overflow_irq}, 0);
        wr(`TC1_OFF_ENABLES, 8'h01);
        repeat (2) @(posedge aclk);
        chk("irq raised", 16'h1, {15'h0, overflow_irq}, 0);
        wr(`TC1_OFF_FLAGS, 8'h01);
        repeat (2) @(posedge aclk);
        chk("irq cleared", 16'h0, {15'h0, overflow_irq}, 0);
        wr(`TC1_OFF_CONTROL, 8'h00);
        $display("overflow test done");
        // A one-count tolerance covers the unknown phase of the instruction-cycle divider.
        for (i = 0; i < 4; i++) begin
            wr(`TC1_OFF_COUNT_HIGH, 8'h00);
            wr(`TC1_OFF_COUNT_LOW, 8'h00);
            wr(`TC1_OFF_CONTROL, {2'b0, i[1:0], 4'h1});
            t = tb_b;
            repeat (400) @(posedge aclk);
            wr(`TC1_OFF_CONTROL, {2'b0, i[1:0], 4'h0});
            rdc(v);
            chk("prescale", 16'((tb_b - t) / (4 << i)), v, 1);
        end
        repeat (40) @(posedge aclk);
        rdc(w);
        chk("stopped hold", v, w, 0);
        $display("prescale test done");
        // Passes 2 and 3 count on the oscillator; pass 2 has it in an unusable system mode.
        for (i = 0; i < 4; i++) begin
            lp_or_intosc_mode <= i != 2;
            wr(`TC1_OFF_CONTROL, {4'h0, i[1:0], 2'b11});
            if (i[1]) repeat (20) @(posedge aclk);
            wr(`TC1_OFF_COUNT_HIGH, 8'h00);
            wr(`TC1_OFF_COUNT_LOW, 8'h00);
            pulses(8'd5);
            rdc(v);
            chk("first edge skipped", i == 2 ? 16'h0 : 16'h4, v, 0);
            pulses(8'd3);
            rdc(v);
            chk("external edges", i == 2 ? 16'h0 : 16'h7, v, 0);
        end
        $display("external count test done");
        for (i = 0; i < 5; i++) begin
            wr(`TC1_OFF_COUNT_HIGH, 8'h80);
            wr(`TC1_OFF_COUNT_LOW, 8'h00);
            wr(`TC1_OFF_CONTROL, i == 4 ? 8'h07 : 8'h01);
            compare_unit_a_mode <= i[1] || i == 4 ? `TC1_CMP_SPECIAL : 4'h2;
            compare_unit_b_mode <= i[1] ? `TC1_CMP_SPECIAL : 4'ha;
            {compare_b_trigger, compare_a_trigger} <= 2'b01 << i[0];
            @(posedge aclk);
            {compare_b_trigger, compare_a_trigger} <= 2'b00;
            wr(`TC1_OFF_CONTROL, 8'h00);
            rdc(v);
            chk("event reset", i == 4 ? 16'h8000 : {i[1] ? 8'h00 : 8'h80, 8'h08}, v, i == 4 ? 0 : 8);
            rd(`TC1_OFF_FLAGS);
            chk("event flag", 16'h0, {8'h0, rv}, 0);
        end
        $display("event trigger test done");
        test_done;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        test_done;
    end
endmodule
